// [pkg/pdb_pkg.sv]
// Purpose: Constants for the packet DMA pointer and address register bank.
// Assumes: 8-bit host slave port, page select held in the command register.
// Notes: Command bit layout beyond the page select field is not decoded here.
package pdb_pkg;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 16;
    localparam int OFS_W = 4;
    localparam int SYNC_STAGES = 2;

    // Page select field inside the command register
    localparam int PS_HIGH_BIT = 7;
    localparam int PS_LOW_BIT = 6;
    localparam logic [1:0] PAGE_0 = 2'h0;
    localparam logic [1:0] PAGE_1 = 2'h1;
    localparam logic [1:0] PAGE_2 = 2'h2;

    // Register offsets
    localparam logic [3:0] OFS_COMMAND = 4'h0;
    localparam logic [3:0] OFS_01 = 4'h1;
    localparam logic [3:0] OFS_02 = 4'h2;
    localparam logic [3:0] OFS_03 = 4'h3;
    localparam logic [3:0] OFS_04 = 4'h4;
    localparam logic [3:0] OFS_05 = 4'h5;
    localparam logic [3:0] OFS_06 = 4'h6;
    localparam logic [3:0] OFS_07 = 4'h7;
    localparam logic [3:0] OFS_08 = 4'h8;
    localparam logic [3:0] OFS_09 = 4'h9;
    localparam logic [3:0] OFS_0A = 4'ha;
    localparam logic [3:0] OFS_0B = 4'hb;
    localparam logic [3:0] OFS_0C = 4'hc;
    localparam logic [3:0] OFS_0D = 4'hd;
    localparam logic [3:0] OFS_0E = 4'he;
    localparam logic [3:0] OFS_0F = 4'hf;
    localparam logic [3:0] OFS_STATION_FIRST = 4'h1;
    localparam logic [3:0] OFS_HASH_FIRST = 4'h8;
    localparam int STATION_BYTES = 6;
    localparam int HASH_BYTES = 8;

    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] PAGE_LOW_ZERO = 8'h00;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam logic [15:0] STEP_WORD = 16'h0002;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
endpackage

// [verilog/pdb_pointer_bank.sv]
// Purpose: Local and remote DMA pointer registers behind the paged host port.
// Assumes: Host strobes are asynchronous pins and are held several cycles.
// Notes: Core events are single-cycle pulses on clock_in.
module pdb_pointer_bank
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic reset_in,
    // Host slave port
    input wire logic host_select_in,
    input wire logic host_read_in,
    input wire logic host_write_in,
    input wire logic [pdb_pkg::OFS_W-1:0] register_offset_lines_in,
    input wire logic [pdb_pkg::BYTE_W-1:0] host_wdata_in,
    output logic [pdb_pkg::BYTE_W-1:0] host_rdata_out,
    output logic host_rdata_oe_out,
    // Configuration readbacks from the core
    input wire logic [pdb_pkg::BYTE_W-1:0] rx_config_in,
    input wire logic [pdb_pkg::BYTE_W-1:0] tx_config_in,
    input wire logic [pdb_pkg::BYTE_W-1:0] data_config_in,
    input wire logic [pdb_pkg::BYTE_W-1:0] irq_mask_in,
    // Local DMA events
    input wire logic tx_start_in,
    input wire logic rx_error_in,
    input wire logic burst_start_in,
    input wire logic burst_end_in,
    input wire logic local_step_in,
    input wire logic link_req_in,
    input wire logic [pdb_pkg::BYTE_W-1:0] next_page_in,
    // Remote DMA events
    input wire logic remote_start_in,
    input wire logic remote_step_in,
    input wire logic remote_word_in,
    // Pointers to the core
    output logic [pdb_pkg::ADDR_W-1:0] local_addr_out,
    output logic local_abort_out,
    output logic ring_full_out,
    output logic [pdb_pkg::BYTE_W-1:0] ring_start_page_out,
    output logic [pdb_pkg::BYTE_W-1:0] ring_stop_page_out,
    output logic [pdb_pkg::BYTE_W-1:0] rx_current_page_out,
    output logic [pdb_pkg::ADDR_W-1:0] tx_byte_count_out,
    output logic [pdb_pkg::ADDR_W-1:0] remote_addr_out,
    output logic [pdb_pkg::ADDR_W-1:0] remote_count_out,
    output logic remote_busy_out,
    output logic remote_done_out,
    output logic [pdb_pkg::BYTE_W*pdb_pkg::STATION_BYTES-1:0] station_out
);
    import pdb_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Host pin synchronisers
    logic [SYNC_STAGES-1:0] sel_sync;
    logic [SYNC_STAGES-1:0] rd_sync;
    logic [SYNC_STAGES-1:0] wr_sync;
    logic [OFS_W-1:0] ofs_sync [SYNC_STAGES];
    logic [BYTE_W-1:0] wd_sync [SYNC_STAGES];
    logic wr_seen;
    logic write_pulse;
    logic read_level;
    logic [OFS_W-1:0] ofs;
    logic [BYTE_W-1:0] wd;

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            sel_sync <= '0;
            rd_sync <= '0;
            wr_sync <= '0;
            wr_seen <= 1'b0;
            for (int i = 0; i < SYNC_STAGES; i++)
            begin
                ofs_sync[i] <= '0;
                wd_sync[i] <= RESET_BYTE;
            end
        end
        else
        begin
            sel_sync <= {sel_sync[SYNC_STAGES-2:0], host_select_in};
            rd_sync <= {rd_sync[SYNC_STAGES-2:0], host_read_in};
            wr_sync <= {wr_sync[SYNC_STAGES-2:0], host_write_in};
            ofs_sync[0] <= register_offset_lines_in;
            wd_sync[0] <= host_wdata_in;
            for (int i = 1; i < SYNC_STAGES; i++)
            begin
                ofs_sync[i] <= ofs_sync[i-1];
                wd_sync[i] <= wd_sync[i-1];
            end
            wr_seen <= wr_sync[SYNC_STAGES-1] & sel_sync[SYNC_STAGES-1];
        end
    end

    assign ofs = ofs_sync[SYNC_STAGES-1];
    assign wd = wd_sync[SYNC_STAGES-1];
    assign read_level = rd_sync[SYNC_STAGES-1] & sel_sync[SYNC_STAGES-1];
    assign write_pulse = wr_sync[SYNC_STAGES-1] & sel_sync[SYNC_STAGES-1]
        & ~wr_seen;

    ////////////////////////////////////////////////////////////////////////
    // Host-only registers
    logic [7:0] command_page_select;
    logic [1:0] page;
    logic [7:0] station [STATION_BYTES];
    logic [7:0] hash_filter [HASH_BYTES];
    logic [7:0] ring_start_page;
    logic [7:0] ring_stop_page;
    logic [7:0] ring_boundary_page;
    logic [7:0] tx_page_start;
    logic [7:0] rx_current_page;
    logic [7:0] remote_next_packet_ptr;
    logic [7:0] local_next_packet_ptr;
    logic [15:0] tx_byte_count;
    logic [15:0] remote_start_addr;
    logic [15:0] remote_count_load;
    logic wr_p0;
    logic wr_p1;
    logic wr_p2;

    assign page = {command_page_select[PS_HIGH_BIT],
        command_page_select[PS_LOW_BIT]};
    assign wr_p0 = write_pulse && page == PAGE_0;
    assign wr_p1 = write_pulse && page == PAGE_1;
    assign wr_p2 = write_pulse && page == PAGE_2;

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            command_page_select <= RESET_BYTE;
            ring_start_page <= RESET_BYTE;
            ring_stop_page <= RESET_BYTE;
            ring_boundary_page <= RESET_BYTE;
            tx_page_start <= RESET_BYTE;
            rx_current_page <= RESET_BYTE;
            remote_next_packet_ptr <= RESET_BYTE;
            local_next_packet_ptr <= RESET_BYTE;
            tx_byte_count <= RESET_WORD;
            remote_start_addr <= RESET_WORD;
            remote_count_load <= RESET_WORD;
            for (int i = 0; i < STATION_BYTES; i++)
                station[i] <= RESET_BYTE;
            for (int i = 0; i < HASH_BYTES; i++)
                hash_filter[i] <= RESET_BYTE;
        end
        else if (write_pulse)
        begin
            // Page 3 and reserved slots ignore writes, except the command register at offset 0
            if (ofs == OFS_COMMAND)
                command_page_select <= wd;
            if (wr_p0)
            begin
                case (ofs)
                    OFS_01: ring_start_page <= wd;
                    OFS_02: ring_stop_page <= wd;
                    OFS_03: ring_boundary_page <= wd;
                    OFS_04: tx_page_start <= wd;
                    OFS_05: tx_byte_count[7:0] <= wd;
                    OFS_06: tx_byte_count[15:8] <= wd;
                    OFS_08: remote_start_addr[7:0] <= wd;
                    OFS_09: remote_start_addr[15:8] <= wd;
                    OFS_0A: remote_count_load[7:0] <= wd;
                    OFS_0B: remote_count_load[15:8] <= wd;
                    default: ;
                endcase
            end
            if (wr_p1)
            begin
                if (ofs >= OFS_STATION_FIRST && ofs <= OFS_06)
                    station[3'(ofs - OFS_STATION_FIRST)] <= wd;
                if (ofs == OFS_07)
                    rx_current_page <= wd;
                if (ofs >= OFS_HASH_FIRST)
                    hash_filter[3'(ofs - OFS_HASH_FIRST)] <= wd;
            end
            if (wr_p2)
            begin
                if (ofs == OFS_03)
                    remote_next_packet_ptr <= wd;
                if (ofs == OFS_05)
                    local_next_packet_ptr <= wd;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Local DMA address counters and saved address
    logic [7:0] addr_counter_upper;
    logic [7:0] addr_counter_lower;
    logic [15:0] local_dma_addr;

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            addr_counter_upper <= RESET_BYTE;
            addr_counter_lower <= RESET_BYTE;
            local_dma_addr <= RESET_WORD;
        end
        else if (rx_error_in)
        begin
            {addr_counter_upper, addr_counter_lower} <=
                {rx_current_page, PAGE_LOW_ZERO};
            local_dma_addr <= {rx_current_page, PAGE_LOW_ZERO};
        end
        else if (tx_start_in)
        begin
            {addr_counter_upper, addr_counter_lower} <=
                {tx_page_start, PAGE_LOW_ZERO};
            local_dma_addr <= {tx_page_start, PAGE_LOW_ZERO};
        end
        else if (burst_start_in)
        begin
            {addr_counter_upper, addr_counter_lower} <= local_dma_addr;
        end
        else if (burst_end_in)
        begin
            local_dma_addr <= {addr_counter_upper, addr_counter_lower};
        end
        else if (local_step_in)
        begin
            {addr_counter_upper, addr_counter_lower} <=
                {addr_counter_upper, addr_counter_lower} + STEP_BYTE;
        end
        else if (wr_p2)
        begin
            // Diagnostic writes
            case (ofs)
                OFS_01: local_dma_addr[7:0] <= wd;
                OFS_02: local_dma_addr[15:8] <= wd;
                OFS_06: addr_counter_upper <= wd;
                OFS_07: addr_counter_lower <= wd;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ring boundary check
    logic boundary_hit;

    assign boundary_hit = link_req_in && next_page_in == ring_boundary_page;

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            local_abort_out <= 1'b0;
            ring_full_out <= 1'b0;
        end
        else
        begin
            local_abort_out <= boundary_hit;
            ring_full_out <= boundary_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Remote DMA address and count
    logic [15:0] remote_addr;
    logic [15:0] remote_count;
    logic remote_busy;
    logic [15:0] remote_inc;

    assign remote_inc = remote_word_in ? STEP_WORD : STEP_BYTE;

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            remote_addr <= RESET_WORD;
            remote_count <= RESET_WORD;
            remote_busy <= 1'b0;
            remote_done_out <= 1'b0;
        end
        else
        begin
            remote_done_out <= 1'b0;
            if (remote_start_in)
            begin
                remote_addr <= remote_start_addr;
                remote_count <= remote_count_load;
                remote_busy <= remote_count_load != RESET_WORD;
                remote_done_out <= remote_count_load == RESET_WORD;
            end
            else if (remote_step_in && remote_busy)
            begin
                remote_addr <= remote_addr + remote_inc;
                if (remote_count <= remote_inc)
                begin
                    remote_count <= RESET_WORD;
                    remote_busy <= 1'b0;
                    remote_done_out <= 1'b1;
                end
                else
                    remote_count <= remote_count - remote_inc;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Host read data
    logic [7:0] next_rdata;

    always_comb
    begin
        next_rdata = RESET_BYTE;
        case (page)
            PAGE_0:
                case (ofs)
                    OFS_COMMAND: next_rdata = command_page_select;
                    OFS_01: next_rdata = local_dma_addr[7:0];
                    OFS_02: next_rdata = local_dma_addr[15:8];
                    OFS_03: next_rdata = ring_boundary_page;
                    OFS_08: next_rdata = remote_addr[7:0];
                    OFS_09: next_rdata = remote_addr[15:8];
                    default: next_rdata = RESET_BYTE;
                endcase
            PAGE_1:
                if (ofs == OFS_COMMAND)
                    next_rdata = command_page_select;
                else if (ofs <= OFS_06)
                    next_rdata = station[3'(ofs - OFS_STATION_FIRST)];
                else if (ofs == OFS_07)
                    next_rdata = rx_current_page;
                else
                    next_rdata = hash_filter[3'(ofs - OFS_HASH_FIRST)];
            PAGE_2:
                case (ofs)
                    OFS_COMMAND: next_rdata = command_page_select;
                    OFS_01: next_rdata = ring_start_page;
                    OFS_02: next_rdata = ring_stop_page;
                    OFS_03: next_rdata = remote_next_packet_ptr;
                    OFS_04: next_rdata = tx_page_start;
                    OFS_05: next_rdata = local_next_packet_ptr;
                    OFS_06: next_rdata = addr_counter_upper;
                    OFS_07: next_rdata = addr_counter_lower;
                    OFS_0C: next_rdata = rx_config_in;
                    OFS_0D: next_rdata = tx_config_in;
                    OFS_0E: next_rdata = data_config_in;
                    OFS_0F: next_rdata = irq_mask_in;
                    default: next_rdata = RESET_BYTE;
                endcase
            default:
                next_rdata = ofs == OFS_COMMAND ? command_page_select
                    : RESET_BYTE;
        endcase
    end

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            host_rdata_out <= RESET_BYTE;
            host_rdata_oe_out <= 1'b0;
        end
        else
        begin
            host_rdata_out <= read_level ? next_rdata : RESET_BYTE;
            host_rdata_oe_out <= read_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs to the core
    assign local_addr_out = {addr_counter_upper, addr_counter_lower};
    assign ring_start_page_out = ring_start_page;
    assign ring_stop_page_out = ring_stop_page;
    assign rx_current_page_out = rx_current_page;
    assign tx_byte_count_out = tx_byte_count;
    assign remote_addr_out = remote_addr;
    assign remote_count_out = remote_count;
    assign remote_busy_out = remote_busy;
    assign station_out = {station[5], station[4], station[3], station[2],
        station[1], station[0]};

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge clock_in); endclocking
    default disable iff (reset_in);

    property p_tx_init;
        !rx_error_in && tx_start_in
            |=> local_addr_out == {$past(tx_page_start), PAGE_LOW_ZERO};
    endproperty
    a_tx_init: assert property (p_tx_init)
        else $error("tx start did not load page start");

    property p_rx_restore;
        rx_error_in
            |=> local_addr_out == {$past(rx_current_page), PAGE_LOW_ZERO}
            && local_dma_addr == {$past(rx_current_page), PAGE_LOW_ZERO};
    endproperty
    a_rx_restore: assert property (p_rx_restore)
        else $error("rx error did not restore current page");

    property p_boundary_hit;
        link_req_in && next_page_in == ring_boundary_page
            |=> local_abort_out && ring_full_out;
    endproperty
    a_boundary_hit: assert property (p_boundary_hit)
        else $error("boundary match did not abort");

    property p_boundary_miss;
        !(link_req_in && next_page_in == ring_boundary_page)
            |=> !local_abort_out;
    endproperty
    a_boundary_miss: assert property (p_boundary_miss)
        else $error("abort without boundary match");

    property p_burst_reload;
        burst_start_in && !rx_error_in && !tx_start_in
            |=> local_addr_out == $past(local_dma_addr);
    endproperty
    a_burst_reload: assert property (p_burst_reload)
        else $error("burst start did not reload counters");

    property p_burst_save;
        burst_end_in && !rx_error_in && !tx_start_in && !burst_start_in
            |=> local_dma_addr == $past(local_addr_out);
    endproperty
    a_burst_save: assert property (p_burst_save)
        else $error("burst end did not save address");

    property p_remote_step;
        remote_busy && remote_step_in && !remote_start_in
            |=> remote_addr == $past(remote_addr) + $past(remote_inc)
            && (remote_count == $past(remote_count) - $past(remote_inc)
            || !remote_busy);
    endproperty
    a_remote_step: assert property (p_remote_step)
        else $error("remote step amount wrong");

    property p_remote_end;
        remote_busy && remote_step_in && !remote_start_in
            && remote_count <= remote_inc
            |=> !remote_busy && remote_done_out ##1 !remote_done_out;
    endproperty
    a_remote_end: assert property (p_remote_end)
        else $error("remote transfer did not end at zero");

    property p_remote_load;
        remote_start_in |=> remote_addr == $past(remote_start_addr)
            && remote_count == $past(remote_count_load);
    endproperty
    a_remote_load: assert property (p_remote_load)
        else $error("remote start did not load address");

    property p_read_oe;
        read_level |=> host_rdata_oe_out
            && host_rdata_out == $past(next_rdata);
    endproperty
    a_read_oe: assert property (p_read_oe)
        else $error("read data not presented");
endmodule

// [verif/pdb_host_model.sv]
// Purpose: Host CPU model driving the paged slave port.
// Assumes: Strobes held long enough for the 2-flop synchronisers.
// Notes: Released data lines show the inverse of the last value.
module pdb_host_model
(
    // Clock
    input wire logic clock_in,
    // Host pins
    output logic sel_out,
    output logic rd_out,
    output logic wr_out,
    output logic [3:0] ofs_out,
    output logic [7:0] wdata_out,
    input wire logic [7:0] rdata_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        sel_out = 1'b0;
        rd_out = 1'b0;
        wr_out = 1'b0;
        ofs_out = 4'h0;
        wdata_out = 8'h00;
    end
    task automatic idle(input int n);
        repeat (n) @(negedge clock_in);
    endtask
    task automatic wr(input logic [3:0] ofs, input logic [7:0] d);
        ofs_out = ofs;
        wdata_out = d;
        sel_out = 1'b1;
        wr_out = 1'b1;
        idle(5);
        sel_out = 1'b0;
        wr_out = 1'b0;
        wdata_out = ~d;
        idle(4);
    endtask
    task automatic rd(input logic [3:0] ofs, output logic [7:0] d);
        ofs_out = ofs;
        sel_out = 1'b1;
        rd_out = 1'b1;
        idle(5);
        d = rdata_in;
        sel_out = 1'b0;
        rd_out = 1'b0;
        idle(4);
    endtask
    // Only pages 0 to 2 are ever selected
    task automatic page(input logic [1:0] p);
        wr(4'h0, {p, 6'h00});
    endtask
endmodule

// [verif/testbench.sv]
// Purpose: Self-checking bench for the DMA pointer bank.
// Assumes: Core events are one-cycle pulses driven at the falling edge.
// Notes: Config readbacks are tied to fixed values.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import pdb_pkg::*;
    logic clock_in, reset_in, host_select_in, host_read_in, host_write_in;
    logic [3:0] register_offset_lines_in;
    logic [7:0] host_wdata_in, host_rdata_out, next_page_in, rv, ev;
    logic [7:0] rx_config_in, tx_config_in, data_config_in, irq_mask_in;
    logic host_rdata_oe_out, tx_start_in, rx_error_in, burst_start_in;
    logic burst_end_in, local_step_in, link_req_in, remote_start_in;
    logic remote_step_in, remote_word_in, local_abort_out, ring_full_out;
    logic remote_busy_out, remote_done_out;
    logic [7:0] ring_start_page_out, ring_stop_page_out, rx_current_page_out;
    logic [15:0] local_addr_out, tx_byte_count_out, remote_addr_out;
    logic [15:0] remote_count_out;
    logic [47:0] station_out;
    logic oe;
    logic [15:0] aborts = 16'h0000, fulls = 16'h0000, dones = 16'h0000;
    int err_total = 0, checked = 0;
    assign {remote_step_in, remote_start_in, link_req_in, local_step_in,
        burst_end_in, burst_start_in, rx_error_in, tx_start_in} = ev;
    pdb_pointer_bank DUT (.*);
    pdb_host_model host
    (
        .clock_in(clock_in),
        .sel_out(host_select_in),
        .rd_out(host_read_in),
        .wr_out(host_write_in),
        .ofs_out(register_offset_lines_in),
        .wdata_out(host_wdata_in),
        .rdata_in(host_rdata_out)
    );
    // Pulses counted outside reset so unknowns before reset stay out of the counts
    always @(posedge clock_in)
    begin
        if (!reset_in)
        begin
            aborts <= aborts + 16'(local_abort_out);
            fulls <= fulls + 16'(ring_full_out);
            dones <= dones + 16'(remote_done_out);
        end
    end
    task automatic chk(input string n, input logic [15:0] e, g);
        checked++;
        if (g !== e)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rc(input logic [3:0] o, input logic [7:0] e, string n);
        // Output enable sampled while the read strobe is still held
        fork
            host.rd(o, rv);
            begin
                repeat (4) @(negedge clock_in);
                oe = host_rdata_oe_out;
            end
        join
        chk(n, {8'h00, e}, {8'h00, rv});
        chk("read_oe", 16'h0001, 16'(oe));
        chk("oe_off", 16'h0000, 16'(host_rdata_oe_out));
        chk("data_off", 16'h0000, 16'(host_rdata_out));
    endtask
    task automatic pulse(input logic [7:0] e);
        ev = e;
        @(negedge clock_in);
        ev = 8'h00;
        @(negedge clock_in);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_page1;
        host.page(PAGE_1);
        for (int i = 0; i < 6; i++)
            host.wr(4'(i + 1), 8'(8'h10 + i));
        host.wr(OFS_07, 8'h46);
        host.wr(OFS_08, 8'ha5);
        host.wr(OFS_0F, 8'h5a);
        chk("station_hi", 16'h1514, station_out[47:32]);
        chk("station_mid", 16'h1312, station_out[31:16]);
        chk("station_lo", 16'h1110, station_out[15:0]);
        chk("cur_out", 16'h0046, 16'(rx_current_page_out));
        rc(OFS_03, 8'h12, "station_2");
        rc(OFS_07, 8'h46, "current_page");
        rc(OFS_08, 8'ha5, "hash_0");
        rc(OFS_0F, 8'h5a, "hash_7");
        $display("test page1 done");
    endtask
    task automatic t_ring;
        host.page(PAGE_0);
        host.wr(OFS_01, 8'h46);
        host.wr(OFS_02, 8'h80);
        host.wr(OFS_03, 8'h50);
        host.wr(OFS_04, 8'h40);
        host.wr(OFS_05, 8'hff);
        host.wr(OFS_06, 8'hff);
        chk("tx_count", 16'hffff, tx_byte_count_out);
        chk("ring_first", 16'h0046, 16'(ring_start_page_out));
        chk("ring_last", 16'h0080, 16'(ring_stop_page_out));
        rc(OFS_03, 8'h50, "boundary");
        host.page(PAGE_2);
        host.wr(OFS_04, 8'h99);
        rc(OFS_01, 8'h46, "ring_start");
        rc(OFS_02, 8'h80, "ring_stop");
        rc(OFS_04, 8'h40, "tx_page");
        rc(OFS_0C, 8'h3c, "rx_cfg");
        rc(OFS_0F, 8'h0f, "irq_mask");
        next_page_in = 8'h50;
        pulse(8'h20);
        next_page_in = 8'h51;
        pulse(8'h20);
        chk("aborts", 16'h0001, aborts);
        chk("fulls", 16'h0001, fulls);
        $display("test ring done");
    endtask
    task automatic t_local;
        pulse(8'h01);
        chk("tx_start", 16'h4000, local_addr_out);
        host.wr(OFS_01, 8'hfe);
        host.wr(OFS_02, 8'h12);
        host.wr(OFS_03, 8'h5c);
        host.wr(OFS_05, 8'h47);
        rc(OFS_03, 8'h5c, "remote_next");
        rc(OFS_05, 8'h47, "local_next");
        pulse(8'h04);
        chk("reload", 16'h12fe, local_addr_out);
        pulse(8'h10);
        pulse(8'h10);
        rc(OFS_06, 8'h13, "counter_hi");
        rc(OFS_07, 8'h00, "counter_lo");
        pulse(8'h08);
        host.page(PAGE_0);
        rc(OFS_01, 8'h00, "saved_lo");
        rc(OFS_02, 8'h13, "saved_hi");
        pulse(8'h02);
        chk("rx_error", 16'h4600, local_addr_out);
        $display("test local done");
    endtask
    task automatic t_remote;
        host.wr(OFS_08, 8'hfe);
        host.wr(OFS_09, 8'h20);
        host.wr(OFS_0A, 8'h03);
        host.wr(OFS_0B, 8'h00);
        pulse(8'h40);
        chk("start", 16'h20fe, remote_addr_out);
        chk("busy", 16'h0001, 16'(remote_busy_out));
        remote_word_in = 1'b1;
        pulse(8'h80);
        chk("word_addr", 16'h2100, remote_addr_out);
        chk("word_count", 16'h0001, remote_count_out);
        remote_word_in = 1'b0;
        pulse(8'h80);
        pulse(8'h80);
        chk("end_count", 16'h0000, remote_count_out);
        chk("end_busy", 16'h0000, 16'(remote_busy_out));
        chk("dones", 16'h0001, dones);
        rc(OFS_08, 8'h01, "cur_lo");
        rc(OFS_09, 8'h21, "cur_hi");
        host.wr(OFS_0A, 8'h00);
        pulse(8'h40);
        chk("zero_busy", 16'h0000, 16'(remote_busy_out));
        chk("zero_done", 16'h0002, dones);
        $display("test remote done");
    endtask
    initial
    begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end
    initial
    begin
        #(5000 * 40);
        err_total++;
        end_of_test();
    end
    initial
    begin
        reset_in = 1'b1;
        ev = 8'h00;
        next_page_in = 8'h00;
        remote_word_in = 1'b0;
        {rx_config_in, tx_config_in} = 16'h3c0d;
        {data_config_in, irq_mask_in} = 16'h490f;
        repeat (4) @(negedge clock_in);
        reset_in = 1'b0;
        repeat (3) @(negedge clock_in);
        t_page1();
        t_ring();
        t_local();
        t_remote();
        end_of_test();
    end
endmodule
